// [shared/pwmcq_pkg.sv]
package pwmcq_pkg;

   // Datapath widths
   localparam int unsigned DATA_W = 32;
   localparam int unsigned ADDR_W = 5;
   localparam int unsigned CNT_W  = 20;
   localparam int unsigned DIV_W  = 8;

   // Register byte offsets
   localparam logic [ADDR_W-1:0] OFS_CTRL   = 5'h00;
   localparam logic [ADDR_W-1:0] OFS_PERIOD = 5'h04;
   localparam logic [ADDR_W-1:0] OFS_DUTY   = 5'h08;
   localparam logic [ADDR_W-1:0] OFS_UPDATE = 5'h0C;
   localparam logic [ADDR_W-1:0] OFS_STATUS = 5'h10;
   localparam logic [ADDR_W-1:0] OFS_COUNT  = 5'h14;

   // Control register field positions
   localparam int unsigned CTRL_EN_BIT    = 0;
   localparam int unsigned CTRL_ALIGN_BIT = 1;
   localparam int unsigned CTRL_IE_BIT    = 2;
   localparam int unsigned CTRL_DIV_LSB   = 8;

   // Status register field positions
   localparam int unsigned STAT_STATE_BIT = 0;
   localparam int unsigned STAT_EVT_BIT   = 1;
   localparam int unsigned STAT_PEND_BIT  = 2;

   // Counter start and restart values
   localparam logic [CNT_W-1:0] CNT_START  = 20'h00000;
   localparam logic [CNT_W-1:0] CNT_RELOAD = 20'h00001;
   localparam logic [CNT_W-1:0] CNT_ONE    = 20'h00001;
   localparam logic [CNT_W-1:0] CNT_ZERO   = 20'h00000;

   // Reset values
   localparam logic [CNT_W-1:0]  PERIOD_RST = 20'h000FF;
   localparam logic [CNT_W-1:0]  DUTY_RST   = 20'h00080;
   localparam logic [DIV_W-1:0]  DIV_RST    = 8'h00;
   localparam logic [DATA_W-1:0] RDATA_IDLE = 32'h00000000;

   // Register port request
   typedef struct packed {
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] wdata;
      logic              wr;
      logic              rd;
   } pwmcq_req_type;

endpackage

// [src/pwmcq_counter.sv]
`timescale 1ns/1ns
// Period counter: restarts from the start value while idle
module pwmcq_counter (
   input  wire logic                         mclk,
   input  wire logic                         rst_n,
   input  wire logic                         run,
   input  wire logic                         tick,
   input  wire logic [pwmcq_pkg::CNT_W-1:0]  limit,
   output logic      [pwmcq_pkg::CNT_W-1:0]  count_q,
   output logic                              wrap
);

   logic [pwmcq_pkg::CNT_W-1:0] count_d;

   // Greater-or-equal guards against a limit lowered below the count
   assign wrap    = run & tick & (count_q >= limit);
   assign count_d = !run ? pwmcq_pkg::CNT_START
                  : wrap ? pwmcq_pkg::CNT_RELOAD
                  : tick ? count_q + pwmcq_pkg::CNT_ONE
                  : count_q;

   // Count register
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         count_q <= pwmcq_pkg::CNT_START;
      end else begin
         count_q <= count_d;
      end
   end

   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rst_n);

   reload_one_a: assert property (wrap |=> count_q == pwmcq_pkg::CNT_RELOAD)
      else $error("counter did not restart at one");
   first_zero_a: assert property ($rose(run) |-> count_q == pwmcq_pkg::CNT_START)
      else $error("first period did not start at zero");
   idle_hold_a: assert property (!run ##1 !run |-> count_q == pwmcq_pkg::CNT_START)
      else $error("idle counter not at start");

endmodule

// [src/pwmcq_top.sv]
// Design decisions made here: the address map and the strobed register port.
`timescale 1ns/1ns
// Function
// - Enabling center-aligned channel raises event flag
// - Later periods restart counting from one
// - First period after enable starts from zero
// - Zero written to update register is ignored
// - State bit reads one for period after disable
module pwmcq_top (
   input  wire logic                          mclk,
   input  wire logic                          reset_n,
   input  wire pwmcq_pkg::pwmcq_req_type      bus_req,
   output logic      [pwmcq_pkg::DATA_W-1:0]  rdata_q,
   output logic                               pwm_out_q,
   output logic                               irq
);

   ////////////////////////////////////////////////////////////////////////////
   // Reset release
   logic rst_meta_q;
   logic rst_n;

   // Assertion is immediate, release waits two edges
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         rst_meta_q <= 1'b0;
         rst_n      <= 1'b0;
      end else begin
         rst_meta_q <= 1'b1;
         rst_n      <= rst_meta_q;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Register decode
   logic                          en_q;
   logic                          align_q;
   logic                          ie_q;
   logic [pwmcq_pkg::DIV_W-1:0]   div_q;
   logic [pwmcq_pkg::CNT_W-1:0]   period_q;
   logic [pwmcq_pkg::CNT_W-1:0]   duty_q;
   logic [pwmcq_pkg::CNT_W-1:0]   upd_val_q;
   logic                          upd_pend_q;
   logic                          event_q;
   logic [pwmcq_pkg::CNT_W-1:0]   drain_q;
   logic [pwmcq_pkg::DIV_W-1:0]   pre_q;
   logic [pwmcq_pkg::CNT_W-1:0]   count;
   logic                          wrap;

   wire wr_ctrl  = bus_req.wr & (bus_req.addr == pwmcq_pkg::OFS_CTRL);
   wire wr_per   = bus_req.wr & (bus_req.addr == pwmcq_pkg::OFS_PERIOD);
   wire wr_duty  = bus_req.wr & (bus_req.addr == pwmcq_pkg::OFS_DUTY);
   wire wr_upd   = bus_req.wr & (bus_req.addr == pwmcq_pkg::OFS_UPDATE);
   wire rd_stat  = bus_req.rd & (bus_req.addr == pwmcq_pkg::OFS_STATUS);
   wire new_en   = bus_req.wdata[pwmcq_pkg::CTRL_EN_BIT];
   wire new_algn = bus_req.wdata[pwmcq_pkg::CTRL_ALIGN_BIT];
   wire [pwmcq_pkg::CNT_W-1:0] wval = bus_req.wdata[pwmcq_pkg::CNT_W-1:0];

   // Enable edges as seen by software writes
   wire turn_on  = wr_ctrl & new_en & !en_q;
   wire turn_off = wr_ctrl & !new_en & en_q;

   ////////////////////////////////////////////////////////////////////////////
   // Prescaler: one-cycle count enable every div_q+1 clocks
   wire tick = (pre_q >= div_q);  // A lowered divider never stalls a wrap

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         pre_q <= pwmcq_pkg::DIV_RST;
      end else begin
         pre_q <= tick ? pwmcq_pkg::DIV_RST : pre_q + 8'h01;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Control and duty registers
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         en_q     <= 1'b0;
         align_q  <= 1'b0;
         ie_q     <= 1'b0;
         div_q    <= pwmcq_pkg::DIV_RST;
         duty_q   <= pwmcq_pkg::DUTY_RST;
      end else if (wr_ctrl) begin
         en_q     <= new_en;
         align_q  <= new_algn;
         ie_q     <= bus_req.wdata[pwmcq_pkg::CTRL_IE_BIT];
         div_q    <= bus_req.wdata[pwmcq_pkg::CTRL_DIV_LSB +: pwmcq_pkg::DIV_W];
      end else if (wr_duty) begin
         duty_q   <= wval;
      end
   end

   // Update register: held until the period ends; zero never latches
   wire upd_take = wr_upd & (wval != pwmcq_pkg::CNT_ZERO);

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         period_q   <= pwmcq_pkg::PERIOD_RST;
         upd_val_q  <= pwmcq_pkg::PERIOD_RST;
         upd_pend_q <= 1'b0;
      end else begin
         if (wr_per) begin
            period_q <= wval;
         end else if (wrap && upd_pend_q) begin
            period_q <= upd_val_q;
         end
         if (upd_take) begin
            upd_val_q <= wval;
         end
         upd_pend_q <= upd_take | (upd_pend_q & !wrap);
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Channel counter
   pwmcq_counter u_cnt (
      .mclk    (mclk),
      .rst_n   (rst_n),
      .run     (en_q),
      .tick    (tick),
      .limit   (period_q),
      .count_q (count),
      .wrap    (wrap)
   );

   // Waveform: high while enabled and the count is below the duty value
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         pwm_out_q <= 1'b0;
      end else begin
         pwm_out_q <= en_q & (count < duty_q);
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Enable state lingers for one period after a disable
   wire state_bit = en_q | (drain_q != pwmcq_pkg::CNT_ZERO);

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         drain_q <= pwmcq_pkg::CNT_ZERO;
      end else if (turn_off) begin
         drain_q <= period_q;
      end else if (en_q) begin
         drain_q <= pwmcq_pkg::CNT_ZERO;
      end else if (tick && state_bit) begin
         drain_q <= drain_q - pwmcq_pkg::CNT_ONE;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Event flag: set wins over the clear by a status read
   wire evt_set = wrap | (turn_on & new_algn);

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         event_q <= 1'b0;
      end else begin
         event_q <= evt_set | (event_q & !rd_stat);
      end
   end

   // Interrupt stays quiet until software enables it
   assign irq = event_q & ie_q;

   ////////////////////////////////////////////////////////////////////////////
   // Read data, valid only in the cycle after the strobe
   logic [pwmcq_pkg::DATA_W-1:0] rd_mux;

   wire [pwmcq_pkg::DATA_W-1:0] ctrl_word = {16'h0000, div_q, 5'h00,
                                             ie_q, align_q, en_q};
   wire [pwmcq_pkg::DATA_W-1:0] stat_word = {29'h00000000, upd_pend_q,
                                             event_q, state_bit};

   always_comb begin
      case (bus_req.addr)
         pwmcq_pkg::OFS_CTRL:   rd_mux = ctrl_word;
         pwmcq_pkg::OFS_PERIOD: rd_mux = {12'h000, period_q};
         pwmcq_pkg::OFS_DUTY:   rd_mux = {12'h000, duty_q};
         pwmcq_pkg::OFS_UPDATE: rd_mux = {12'h000, upd_val_q};
         pwmcq_pkg::OFS_STATUS: rd_mux = stat_word;
         pwmcq_pkg::OFS_COUNT:  rd_mux = {12'h000, count};
         default:               rd_mux = pwmcq_pkg::RDATA_IDLE;
      endcase
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         rdata_q <= pwmcq_pkg::RDATA_IDLE;
      end else begin
         rdata_q <= bus_req.rd ? rd_mux : pwmcq_pkg::RDATA_IDLE;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Checks
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rst_n);

   center_evt_a: assert property (turn_on && new_algn |=> event_q)
      else $error("center enable raised no event");
   edge_evt_a: assert property (turn_on && !new_algn && !wrap && !event_q
                                |=> !event_q)
      else $error("edge enable raised an event");
   zero_upd_a: assert property (wr_upd && wval == pwmcq_pkg::CNT_ZERO
                                && !wrap && !wr_per
                                |=> $stable(upd_pend_q) && $stable(period_q))
      else $error("zero update took effect");
   state_hold_a: assert property (turn_off
                                  && period_q > pwmcq_pkg::CNT_ONE
                                  |=> state_bit [*2])
      else $error("state bit dropped at disable");
   drain_end_a: assert property ($fell(state_bit) |->
                                 !en_q && drain_q == pwmcq_pkg::CNT_ZERO
                                 && ($past(tick) || $past(turn_off)))
      else $error("state bit dropped early");
   read_clear_a: assert property (rd_stat && !evt_set |=> !event_q)
      else $error("status read left event set");
   rdata_idle_a: assert property (!$past(bus_req.rd) |->
                                  rdata_q == pwmcq_pkg::RDATA_IDLE)
      else $error("read data outside read slot");
   out_idle_a: assert property (!en_q |=> !pwm_out_q)
      else $error("output active while disabled");
   upd_apply_a: assert property (wrap && upd_pend_q && !wr_per
                                 |=> period_q == $past(upd_val_q))
      else $error("pending update not applied");

   center_on_c: cover property (turn_on && new_algn);
   wrap_c:      cover property (wrap ##[1:50] wrap);
   drain_c:     cover property (turn_off ##[1:300] $fell(state_bit));
   upd_c:       cover property (upd_take ##[1:300] wrap);

endmodule

// [tb/pwmcq_load.sv]
`timescale 1ns/1ns
////////////////////////////////////////////////////////////////////////
// External load: times the gap between rising edges of the waveform
module pwmcq_load (
   input  wire logic        mclk,
   input  wire logic        pwm_in,
   output logic      [15:0] gap_q,
   output logic      [7:0]  rises_q
);
   logic        prev_q = 1'b0;
   logic [15:0] run_q  = 16'h0000;

   initial begin
      gap_q   = 16'h0000;
      rises_q = 8'h00;
   end

   // A rise closes one gap; the load has no reset, so it starts from zero
   always @(posedge mclk) begin
      prev_q <= pwm_in;
      run_q  <= run_q + 16'h0001;
      if (pwm_in && !prev_q) begin
         gap_q   <= run_q;
         run_q   <= 16'h0001;
         rises_q <= rises_q + 8'h01;
      end
   end
endmodule

// [tb/tb_pwmcq_top.sv]
`timescale 1ns/1ns
`define CHK(a, e) begin checks++; if ((a) !== (e)) begin fails++; \
   $display("wrong value at %0t got %h exp %h", $time, a, e); end end
////////////////////////////////////////////////////////////////////////
module tb_pwmcq_top;
   logic                      mclk;
   logic                      reset_n;
   pwmcq_pkg::pwmcq_req_type  req;
   logic [31:0]               rdata_q;
   logic                      pwm_out_q;
   logic                      irq;
   logic [15:0]               gap;
   logic [7:0]                rises;
   logic [31:0]               rd_v;
   int                        fails = 0;
   int                        checks = 0;
   int                        cyc = 0;

   pwmcq_top dut_u (.mclk(mclk), .reset_n(reset_n), .bus_req(req),
      .rdata_q(rdata_q), .pwm_out_q(pwm_out_q), .irq(irq));
   pwmcq_load load_u (.mclk(mclk), .pwm_in(pwm_out_q), .gap_q(gap),
      .rises_q(rises));

   // Free-running clock, 40 ns period
   initial begin
      mclk = 1'b0;
      forever #20 mclk = ~mclk;
   end

   // Hang guard, well above the few hundred cycles the tests need
   always @(posedge mclk) begin
      cyc++;
      if (cyc == 20000) begin
         fails++;
         summarize();
      end
   end

   task automatic summarize();
      $display("checks %0d fails %0d", checks, fails);
      if (fails == 0 && checks > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask

   task automatic tick(input int n);
      repeat (n) @(posedge mclk);
   endtask

   // One write, then an idle edge so the strobe is never set twice at once
   task automatic wr(input logic [4:0] a, input logic [31:0] d);
      req.addr  <= a;
      req.wdata <= d;
      req.wr    <= 1'b1;
      @(posedge mclk);
      req.wr    <= 1'b0;
      @(posedge mclk);
   endtask

   // Read data stand only in the cycle after the strobe
   task automatic rd(input logic [4:0] a);
      req.addr <= a;
      req.rd   <= 1'b1;
      @(posedge mclk);
      req.rd   <= 1'b0;
      #1 rd_v = rdata_q;
      @(posedge mclk);
   endtask

   task automatic wait_rise(input int n);
      int k;
      logic [7:0] r;
      repeat (n) begin
         k = 0;
         r = rises;
         while (rises == r && k < 1000) begin
            @(posedge mclk);
            k++;
         end
         if (rises == r) fails++;
      end
   endtask

   ////////////////////////////////////////////////////////////////////
   initial begin
      reset_n = 1'b0;
      req = '0;
      tick(5);
      reset_n <= 1'b1;
      tick(3);
      // Reset values and an unmapped read
      rd(pwmcq_pkg::OFS_PERIOD); `CHK(rd_v, 32'h000000FF)
      rd(pwmcq_pkg::OFS_DUTY);   `CHK(rd_v, 32'h00000080)
      rd(pwmcq_pkg::OFS_STATUS); `CHK(rd_v, 32'h00000000)
      rd(5'h18);                 `CHK(rd_v, 32'h00000000)
      rd(pwmcq_pkg::OFS_COUNT);  `CHK(rd_v, 32'h00000000)
      #1 `CHK(rdata_q, 32'h00000000)
      $display("test reset done");
      // Period lengths, prescale 0 and 1; start-up timing of the
      // prescaler is left open, so the first gap is judged at 0 only
      for (int dv = 0; dv < 2; dv++) begin
         wr(pwmcq_pkg::OFS_PERIOD, 32'h0000000A);
         wr(pwmcq_pkg::OFS_DUTY, 32'h00000004);
         wr(pwmcq_pkg::OFS_CTRL, {16'h0000, 8'(dv), 8'h01});
         wait_rise(2);
         if (dv == 0) `CHK(gap, 16'h000B)
         wait_rise(1);
         `CHK(gap, 16'(10 * (dv + 1)))
         wr(pwmcq_pkg::OFS_CTRL, 32'h00000000);
         tick(40);
      end
      $display("test period done");
      // Zero update refused, non-zero update taken at the wrap
      // Wraps of the period test left the event flag set; clear it first
      rd(pwmcq_pkg::OFS_STATUS);
      wr(pwmcq_pkg::OFS_CTRL, 32'h00000001);
      wr(pwmcq_pkg::OFS_UPDATE, 32'h00000000);
      rd(pwmcq_pkg::OFS_STATUS);
      `CHK(rd_v[2], 1'b0)
      `CHK(rd_v[1], 1'b0)
      wait_rise(3);
      `CHK(gap, 16'h000A)
      wr(pwmcq_pkg::OFS_UPDATE, 32'h00000006);
      rd(pwmcq_pkg::OFS_STATUS);
      `CHK(rd_v[2], 1'b1)
      wait_rise(3);
      `CHK(gap, 16'h0006)
      $display("test update done");
      // Disable in mid-period: state bit lingers, output drops at once
      wr(pwmcq_pkg::OFS_CTRL, 32'h00000000);
      rd(pwmcq_pkg::OFS_STATUS);
      `CHK(rd_v[0], 1'b1)
      `CHK(pwm_out_q, 1'b0)
      tick(14);
      rd(pwmcq_pkg::OFS_STATUS);
      `CHK(rd_v[0], 1'b0)
      $display("test disable done");
      // Center-aligned enable event, cleared by the status read
      wr(pwmcq_pkg::OFS_PERIOD, 32'h00000014);
      wr(pwmcq_pkg::OFS_CTRL, 32'h00000003);
      rd(pwmcq_pkg::OFS_STATUS);
      `CHK(rd_v[1], 1'b1)
      rd(pwmcq_pkg::OFS_STATUS);
      `CHK(rd_v[1], 1'b0)
      wr(pwmcq_pkg::OFS_CTRL, 32'h00000007);
      #1 `CHK(irq, 1'b0)
      rd(pwmcq_pkg::OFS_CTRL);   `CHK(rd_v, 32'h00000007)
      wait_rise(2);
      #1 `CHK(irq, 1'b1)
      rd(pwmcq_pkg::OFS_STATUS);
      #1 `CHK(irq, 1'b0)
      $display("test event done");
      summarize();
   end
endmodule
